/* hdl/dcs_channel.sv */
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Function
// - Start bit begins channel, awaits first request
// - Chained start fetches first table entry
// - One operand moved per honoured request
// - Chained block end reloads from table
// - Continue mode reloads from base registers
// - Done, count zero, error, aborts terminate
// - Pointer is 24-bit address, 3-bit code
// - 16-bit count decrements; address steps
// - Even address holds high-order byte
// - Word and long operands need even address
// - Operand size from operation control field
// - Device control selects type and port
// - Ports 8/16 bits, accessed full width
// - Line is ready or enable clock
// - Otherwise line has one of four functions
// - Line level readable in status register
// - Falling line edge sets transition bit
// - Status-interrupt function raises interrupt request
// - Abort function terminates, status shows abort
// - Start pulse drives line low eight clocks
// - Single-address size mismatches are illegal
// - Dual byte on 16-bit needs internal requests
module dcs_channel #(
	parameter int PULSE_CLKS = dcs_pkg::DCS_PULSE_CLKS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Requests and aborts from outside
	input wire logic xfer_request,
	input wire logic ext_abort,
	// Peripheral control line (three signals) and its decoded outputs
	input wire logic peripheral_control_line_in,
	output logic peripheral_control_line_out,
	output logic peripheral_control_line_oe_n,
	output logic device_ready,
	output logic sync_enable_clk,
	output logic line_irq,
	// Transfer engine to bus mover
	output dcs_pkg::dcs_xfer_req_type xfer_req,
	input wire dcs_pkg::dcs_xfer_rsp_type xfer_rsp
);
	import dcs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		dcs_state_type st;
		logic [9:0] operation_control_reg;
		logic [4:0] device_control_reg;
		logic int_en;
		dcs_ptr_type memory_address_reg;
		logic [DCS_CNT_W-1:0] mtc;
		dcs_ptr_type bar;
		logic [DCS_CNT_W-1:0] btc;
		dcs_ptr_type device_address_reg;
		logic done_f;
		logic err_f;
		logic abrt_f;
		logic ltr_f;
		logic line_prev;
		logic [3:0] pulse_cnt;
		logic rd_ack;
		logic [31:0] rdata;
	} dcs_regs_type;

	dcs_regs_type r_q;
	dcs_regs_type r_d;

	logic [1:0] size_w;
	logic [1:0] dtype_w;
	logic [1:0] lfn_w;
	logic [1:0] chain_w;
	logic [1:0] req_w;
	logic [1:0] minc_w;
	logic legal_w;
	logic line_fall_w;
	logic sw_start_w;
	logic sw_abort_w;
	logic line_abort_w;
	logic kill_w;
	logic wr_w;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Bytes per operand
	function automatic logic [2:0] op_bytes(input logic [1:0] sz);
		case (sz)
			DCS_SZ_BYTE: op_bytes = 3'h1;
			DCS_SZ_WORD: op_bytes = 3'h2;
			default: op_bytes = 3'h4;
		endcase
	endfunction

	// Size, port and protocol legality check
	function automatic logic combo_ok(input logic [1:0] sz, input logic p16, input logic dual,
		input logic [1:0] rq, input logic [1:0] dt, input logic [DCS_ADDR_W-1:0] ma);
		logic ok;
		ok = (sz != 2'h3);
		if (!dual) begin
			ok = ok && (p16 ? (sz == DCS_SZ_WORD) : (sz == DCS_SZ_BYTE));
		end else if (p16 && sz == DCS_SZ_BYTE) begin
			ok = ok && (rq == DCS_RQ_MAX || rq == DCS_RQ_LIM);
		end
		if (dual && !p16 && dt == DCS_DEV_ASYNC && (rq == DCS_RQ_MAX || rq == DCS_RQ_LIM)) begin
			ok = 1'b0;
		end
		if (sz != DCS_SZ_BYTE && ma[0]) begin
			ok = 1'b0;
		end
		combo_ok = ok;
	endfunction

	// Step a pointer by the operand size
	function automatic logic [DCS_ADDR_W-1:0] step(input logic [DCS_ADDR_W-1:0] a, input logic [1:0] md,
		input logic [1:0] sz);
		logic [DCS_ADDR_W-1:0] d;
		d = {{(DCS_ADDR_W-3){1'b0}}, op_bytes(sz)};
		case (md)
			DCS_AS_INC: step = a + d;
			DCS_AS_DEC: step = a - d;
			default: step = a;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Decodes
	assign size_w = r_q.operation_control_reg[DCS_OCR_SIZE_LSB +: 2];
	assign chain_w = r_q.operation_control_reg[DCS_OCR_CHAIN_LSB +: 2];
	assign req_w = r_q.operation_control_reg[DCS_OCR_REQ_LSB +: 2];
	assign minc_w = r_q.operation_control_reg[DCS_OCR_MINC_LSB +: 2];
	assign dtype_w = r_q.device_control_reg[DCS_DCR_TYPE_LSB +: 2];
	assign lfn_w = r_q.device_control_reg[DCS_DCR_LFN_LSB +: 2];
	assign legal_w = combo_ok(size_w, r_q.device_control_reg[DCS_DCR_PORT16], r_q.operation_control_reg[DCS_OCR_DUAL], req_w, dtype_w,
		r_q.memory_address_reg.addr);
	assign line_fall_w = r_q.line_prev && !peripheral_control_line_in;
	assign wr_w = avs_write && !avs_read;
	assign sw_start_w = wr_w && avs_address == DCS_CCR_OFF && avs_writedata[DCS_CCR_START];
	assign sw_abort_w = wr_w && avs_address == DCS_CCR_OFF && avs_writedata[DCS_CCR_ABORT];
	assign line_abort_w = lfn_w == DCS_LF_ABORT && dtype_w != DCS_DEV_SYNC && dtype_w != DCS_DEV_ACKRDY
		&& (r_q.ltr_f || line_fall_w);
	assign kill_w = sw_abort_w || ext_abort || line_abort_w;

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		r_d = r_q;
		r_d.rd_ack = 1'b0;
		r_d.line_prev = peripheral_control_line_in;
		if (line_fall_w) begin
			r_d.ltr_f = 1'b1;
		end
		if (r_q.pulse_cnt != 4'h0) begin
			r_d.pulse_cnt = r_q.pulse_cnt - 4'h1;
		end
		// Register writes
		if (wr_w && r_q.st == DCS_IDLE) begin
			case (avs_address)
				DCS_OCR_OFF: r_d.operation_control_reg = avs_writedata[9:0];
				DCS_DCR_OFF: r_d.device_control_reg = avs_writedata[4:0];
				DCS_MAR_OFF: r_d.memory_address_reg = avs_writedata[26:0];
				DCS_MTC_OFF: r_d.mtc = avs_writedata[15:0];
				DCS_BAR_OFF: r_d.bar = avs_writedata[26:0];
				DCS_BTC_OFF: r_d.btc = avs_writedata[15:0];
				DCS_DAR_OFF: r_d.device_address_reg = avs_writedata[26:0];
				default: r_d.int_en = r_q.int_en;
			endcase
		end
		if (wr_w && avs_address == DCS_INT_OFF) begin
			r_d.int_en = avs_writedata[0];
		end
		// Status clear by writing ones; new events win
		if (wr_w && avs_address == DCS_CSR_OFF) begin
			r_d.done_f = r_q.done_f && !avs_writedata[DCS_CSR_DONE];
			r_d.err_f = r_q.err_f && !avs_writedata[DCS_CSR_ERR];
			r_d.abrt_f = r_q.abrt_f && !avs_writedata[DCS_CSR_ABRT];
			r_d.ltr_f = (r_q.ltr_f && !avs_writedata[DCS_CSR_LTR]) || line_fall_w;
		end
		// Register reads
		if (avs_read && !r_q.rd_ack) begin
			r_d.rd_ack = 1'b1;
			case (avs_address)
				DCS_CCR_OFF: r_d.rdata = {31'h0, r_q.st != DCS_IDLE};
				DCS_OCR_OFF: r_d.rdata = {22'h0, r_q.operation_control_reg};
				DCS_DCR_OFF: r_d.rdata = {27'h0, r_q.device_control_reg};
				DCS_CSR_OFF: r_d.rdata = {26'h0, peripheral_control_line_in, r_q.ltr_f,
					r_q.st != DCS_IDLE, r_q.abrt_f, r_q.err_f, r_q.done_f};
				DCS_MAR_OFF: r_d.rdata = {5'h0, r_q.memory_address_reg};
				DCS_MTC_OFF: r_d.rdata = {16'h0, r_q.mtc};
				DCS_BAR_OFF: r_d.rdata = {5'h0, r_q.bar};
				DCS_BTC_OFF: r_d.rdata = {16'h0, r_q.btc};
				DCS_DAR_OFF: r_d.rdata = {5'h0, r_q.device_address_reg};
				DCS_INT_OFF: r_d.rdata = {31'h0, r_q.int_en};
				default: r_d.rdata = 32'h0;
			endcase
		end
		// Channel sequence
		case (r_q.st)
			DCS_IDLE: begin
				if (sw_start_w) begin
					if (!legal_w) begin
						r_d.err_f = 1'b1;
					end else begin
						if (lfn_w == DCS_LF_PULSE) begin
							r_d.pulse_cnt = PULSE_CLKS[3:0];
						end
						r_d.st = (chain_w == DCS_CH_NONE) ? DCS_WAIT : DCS_FETCH;
					end
				end
			end
			DCS_FETCH: begin
				if (kill_w) begin
					r_d.abrt_f = 1'b1;
					r_d.st = DCS_IDLE;
				end else if (xfer_rsp.done) begin
					if (xfer_rsp.bus_error) begin
						r_d.err_f = 1'b1;
						r_d.st = DCS_IDLE;
					end else begin
						r_d.memory_address_reg = xfer_rsp.tbl_mem;
						r_d.mtc = xfer_rsp.tbl_count;
						if (chain_w == DCS_CH_LINK) begin
							r_d.bar.addr = xfer_rsp.tbl_link;
						end else begin
							r_d.bar.addr = r_q.bar.addr + 24'h6;
							r_d.btc = r_q.btc - 16'h1;
						end
						r_d.st = DCS_WAIT;
					end
				end
			end
			DCS_WAIT: begin
				if (kill_w) begin
					r_d.abrt_f = 1'b1;
					r_d.st = DCS_IDLE;
				end else if (xfer_request || req_w == DCS_RQ_MAX) begin
					r_d.st = DCS_MOVE;
				end
			end
			DCS_MOVE: begin
				if (xfer_rsp.done) begin
					if (xfer_rsp.bus_error) begin
						r_d.err_f = 1'b1;
						r_d.st = DCS_IDLE;
					end else begin
						r_d.memory_address_reg.addr = step(r_q.memory_address_reg.addr, minc_w, size_w);
						r_d.mtc = r_q.mtc - 16'h1;
						r_d.st = xfer_rsp.periph_done ? DCS_IDLE : DCS_NEXT;
						r_d.done_f = r_d.done_f || xfer_rsp.periph_done;
					end
				end else if (kill_w) begin
					r_d.abrt_f = 1'b1;
					r_d.st = DCS_IDLE;
				end
			end
			DCS_NEXT: begin
				if (kill_w) begin
					r_d.abrt_f = 1'b1;
					r_d.st = DCS_IDLE;
				end else if (r_q.mtc != 16'h0) begin
					r_d.st = DCS_WAIT;
				end else if (chain_w == DCS_CH_LINK && r_q.bar.addr != 24'h0) begin
					r_d.st = DCS_FETCH;
				end else if (chain_w == DCS_CH_ARRAY && r_q.btc != 16'h0) begin
					r_d.st = DCS_FETCH;
				end else if (chain_w == DCS_CH_NONE && r_q.operation_control_reg[DCS_OCR_CONT]) begin
					r_d.memory_address_reg = r_q.bar;
					r_d.mtc = r_q.btc;
					r_d.st = DCS_WAIT;
				end else begin
					r_d.done_f = 1'b1;
					r_d.st = DCS_IDLE;
				end
			end
			default: r_d.st = DCS_IDLE;
		endcase
		if (!rst_n) begin
			r_d = '0;
			r_d.line_prev = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register stage
	always_ff @(posedge sys_clk) begin
		r_q <= r_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign avs_readdata = r_q.rdata;
	assign avs_waitrequest = avs_read && !r_q.rd_ack;
	assign peripheral_control_line_out = 1'b0;
	assign peripheral_control_line_oe_n = !(r_q.pulse_cnt != 4'h0 && dtype_w != DCS_DEV_SYNC
		&& dtype_w != DCS_DEV_ACKRDY && lfn_w == DCS_LF_PULSE);
	assign device_ready = dtype_w == DCS_DEV_ACKRDY && !peripheral_control_line_in;
	assign sync_enable_clk = dtype_w == DCS_DEV_SYNC && peripheral_control_line_in;
	assign line_irq = lfn_w == DCS_LF_STATINT && dtype_w != DCS_DEV_SYNC && dtype_w != DCS_DEV_ACKRDY
		&& r_q.ltr_f && r_q.int_en;

	// Bus mover request; port width is passed through for full-width access
	always_comb begin
		xfer_req = '0;
		xfer_req.valid = r_q.st == DCS_MOVE || r_q.st == DCS_FETCH;
		xfer_req.table_fetch = r_q.st == DCS_FETCH;
		xfer_req.mem = (r_q.st == DCS_FETCH) ? r_q.bar : r_q.memory_address_reg;
		xfer_req.dev = r_q.device_address_reg;
		xfer_req.size = size_w;
		xfer_req.dual = r_q.operation_control_reg[DCS_OCR_DUAL];
		xfer_req.dev_type = dtype_w;
		xfer_req.port16 = r_q.device_control_reg[DCS_DCR_PORT16];
	end

endmodule

/* hdl/dcs_pkg.sv */
package dcs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [5:0] DCS_CCR_OFF = 6'h00;
	localparam logic [5:0] DCS_OCR_OFF = 6'h04;
	localparam logic [5:0] DCS_DCR_OFF = 6'h08;
	localparam logic [5:0] DCS_CSR_OFF = 6'h0c;
	localparam logic [5:0] DCS_MAR_OFF = 6'h10;
	localparam logic [5:0] DCS_MTC_OFF = 6'h14;
	localparam logic [5:0] DCS_BAR_OFF = 6'h18;
	localparam logic [5:0] DCS_BTC_OFF = 6'h1c;
	localparam logic [5:0] DCS_DAR_OFF = 6'h20;
	localparam logic [5:0] DCS_INT_OFF = 6'h24;

	// Channel control bits
	localparam int DCS_CCR_START = 0;
	localparam int DCS_CCR_ABORT = 1;
	// Operation control fields
	localparam int DCS_OCR_SIZE_LSB = 0;
	localparam int DCS_OCR_DUAL = 2;
	localparam int DCS_OCR_CHAIN_LSB = 3;
	localparam int DCS_OCR_CONT = 5;
	localparam int DCS_OCR_REQ_LSB = 6;
	localparam int DCS_OCR_MINC_LSB = 8;
	// Device control fields
	localparam int DCS_DCR_TYPE_LSB = 0;
	localparam int DCS_DCR_PORT16 = 2;
	localparam int DCS_DCR_LFN_LSB = 3;
	// Status bits
	localparam int DCS_CSR_DONE = 0;
	localparam int DCS_CSR_ERR = 1;
	localparam int DCS_CSR_ABRT = 2;
	localparam int DCS_CSR_ACT = 3;
	localparam int DCS_CSR_LTR = 4;
	localparam int DCS_CSR_LST = 5;

	// Widths and timing
	localparam int DCS_ADDR_W = 24;
	localparam int DCS_FC_W = 3;
	localparam int DCS_CNT_W = 16;
	localparam int DCS_PULSE_CLKS = 8;

	// Operand sizes
	localparam logic [1:0] DCS_SZ_BYTE = 2'h0;
	localparam logic [1:0] DCS_SZ_WORD = 2'h1;
	localparam logic [1:0] DCS_SZ_LONG = 2'h2;
	// Device types
	localparam logic [1:0] DCS_DEV_ASYNC = 2'h0;
	localparam logic [1:0] DCS_DEV_SYNC = 2'h1;
	localparam logic [1:0] DCS_DEV_ACK = 2'h2;
	localparam logic [1:0] DCS_DEV_ACKRDY = 2'h3;
	// Line functions
	localparam logic [1:0] DCS_LF_STATUS = 2'h0;
	localparam logic [1:0] DCS_LF_STATINT = 2'h1;
	localparam logic [1:0] DCS_LF_ABORT = 2'h2;
	localparam logic [1:0] DCS_LF_PULSE = 2'h3;
	// Chain modes
	localparam logic [1:0] DCS_CH_NONE = 2'h0;
	localparam logic [1:0] DCS_CH_ARRAY = 2'h2;
	localparam logic [1:0] DCS_CH_LINK = 2'h3;
	// Request methods
	localparam logic [1:0] DCS_RQ_MAX = 2'h0;
	localparam logic [1:0] DCS_RQ_LIM = 2'h1;
	// Address step modes
	localparam logic [1:0] DCS_AS_HOLD = 2'h0;
	localparam logic [1:0] DCS_AS_INC = 2'h1;
	localparam logic [1:0] DCS_AS_DEC = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Channel states
	typedef enum logic [2:0] {
		DCS_IDLE = 3'b000,
		DCS_FETCH = 3'b001,
		DCS_WAIT = 3'b010,
		DCS_MOVE = 3'b011,
		DCS_NEXT = 3'b100
	} dcs_state_type;

	// Memory pointer: function code plus address
	typedef struct packed {
		logic [DCS_FC_W-1:0] fc;
		logic [DCS_ADDR_W-1:0] addr;
	} dcs_ptr_type;

	// Avalon-MM slave request
	typedef struct packed {
		logic read;
		logic write;
		logic [5:0] address;
		logic [31:0] writedata;
	} dcs_avm_req_type;

	// Transfer engine request to system bus mover
	typedef struct packed {
		logic valid;
		logic table_fetch;
		dcs_ptr_type mem;
		dcs_ptr_type dev;
		logic [1:0] size;
		logic dual;
		logic [1:0] dev_type;
		logic port16;
	} dcs_xfer_req_type;

	// Mover response
	typedef struct packed {
		logic done;
		logic bus_error;
		logic periph_done;
		dcs_ptr_type tbl_mem;
		logic [DCS_CNT_W-1:0] tbl_count;
		logic [DCS_ADDR_W-1:0] tbl_link;
	} dcs_xfer_rsp_type;

endpackage

/* testbench/dcs_chk.sv */
`timescale 1ns/1ps
// Port-level checks of the channel
module dcs_chk #(
	parameter int PULSE_CLKS = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register bus
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Requests, aborts and control line
	input wire logic xfer_request,
	input wire logic ext_abort,
	input wire logic peripheral_control_line_in,
	input wire logic peripheral_control_line_out,
	input wire logic peripheral_control_line_oe_n,
	input wire logic device_ready,
	input wire logic sync_enable_clk,
	input wire logic line_irq,
	// Mover side
	input wire dcs_pkg::dcs_xfer_req_type xfer_req,
	input wire dcs_pkg::dcs_xfer_rsp_type xfer_rsp
);
	import dcs_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake, control line and mover requests
	a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
		else $error("write stalled");
	a_read_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("read wait too long");
	a_pulse_len: assert property ($fell(peripheral_control_line_oe_n) |->
		!peripheral_control_line_oe_n [*8] ##1 peripheral_control_line_oe_n) else $error("bad pulse length");
	a_ready_line: assert property (device_ready |-> !peripheral_control_line_in)
		else $error("ready without low line");
	a_sync_line: assert property (sync_enable_clk |-> peripheral_control_line_in)
		else $error("enable clock not line level");
	a_even_addr: assert property (xfer_req.valid && !xfer_req.table_fetch && xfer_req.size != DCS_SZ_BYTE
		|-> !xfer_req.mem.addr[0]) else $error("odd operand address");
	a_legal_size: assert property (xfer_req.valid && !xfer_req.table_fetch && !xfer_req.dual
		|-> xfer_req.size == (xfer_req.port16 ? DCS_SZ_WORD : DCS_SZ_BYTE)) else $error("illegal size moved");
	a_req_hold: assert property (xfer_req.valid && !xfer_rsp.done && !avs_write && !ext_abort
		&& peripheral_control_line_in |=> xfer_req.valid && $stable(xfer_req.mem)) else $error("request dropped");
	a_abort_stop: assert property (ext_abort |=> !xfer_req.valid)
		else $error("abort ignored");
endmodule

bind dcs_channel dcs_chk #(.PULSE_CLKS(PULSE_CLKS)) i_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .xfer_request(xfer_request), .ext_abort(ext_abort),
	.peripheral_control_line_in(peripheral_control_line_in), .peripheral_control_line_out(peripheral_control_line_out),
	.peripheral_control_line_oe_n(peripheral_control_line_oe_n), .device_ready(device_ready),
	.sync_enable_clk(sync_enable_clk), .line_irq(line_irq), .xfer_req(xfer_req), .xfer_rsp(xfer_rsp)
);

/* testbench/dcs_mover.sv */
`timescale 1ns/1ps
// Bus mover model: answers requests, serves command table entries
module dcs_mover (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Channel side
	input wire dcs_pkg::dcs_xfer_req_type xfer_req,
	output dcs_pkg::dcs_xfer_rsp_type xfer_rsp,
	// Scenario controls
	input wire logic [3:0] delay,
	input wire logic bus_err,
	input wire logic pdone,
	input wire dcs_pkg::dcs_ptr_type t_mem,
	input wire logic [15:0] t_cnt
);
	import dcs_pkg::*;
	int wait_q;
	int moves;
	logic [23:0] addrs [$];
	logic [23:0] fetch_addr;

	////////////////////////////////////////////////////////////////////////////////
	// Answer after delay cycles; table data is only valid with done, else it toggles
	always_ff @(posedge sys_clk) begin
		xfer_rsp <= {3'h0, ~xfer_rsp[66:0]};
		if (!rst_n) begin
			xfer_rsp <= '0;
			wait_q <= 0;
			moves <= 0;
		end else if (!xfer_req.valid || xfer_rsp.done) begin
			wait_q <= 0;
		end else if (wait_q < int'(delay)) begin
			wait_q <= wait_q + 1;
		end else begin
			xfer_rsp.done <= 1'b1;
			xfer_rsp.bus_error <= bus_err;
			xfer_rsp.periph_done <= pdone;
			if (xfer_req.table_fetch) begin
				xfer_rsp.tbl_mem <= t_mem;
				xfer_rsp.tbl_count <= t_cnt;
				xfer_rsp.tbl_link <= '0;
				fetch_addr <= xfer_req.mem.addr;
			end else begin
				moves <= moves + 1;
				addrs.push_back(xfer_req.mem.addr);
			end
		end
	end
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
// Channel bench against the mover model
module tb_top;
	import dcs_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ext_abort = 1'b0;
	logic xfer_request = 1'b0;
	logic pcl_drv = 1'b1;
	logic pcl_out;
	logic pcl_oe_n;
	logic device_ready;
	logic sync_enable_clk;
	logic line_irq;
	dcs_xfer_req_type xfer_req;
	dcs_xfer_rsp_type xfer_rsp;
	logic [3:0] delay = 4'h0;
	logic bus_err = 1'b0;
	logic pdone = 1'b0;
	dcs_ptr_type t_mem = {3'h5, 24'h000500};
	logic [31:0] rdata;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	int low_cnt = 0;
	int base = 0;
	wire logic pcl_line = pcl_oe_n ? pcl_drv : pcl_out;

	dcs_channel #(.PULSE_CLKS(8)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .xfer_request(xfer_request), .ext_abort(ext_abort),
		.peripheral_control_line_in(pcl_line), .peripheral_control_line_out(pcl_out),
		.peripheral_control_line_oe_n(pcl_oe_n), .device_ready(device_ready), .sync_enable_clk(sync_enable_clk),
		.line_irq(line_irq), .xfer_req(xfer_req), .xfer_rsp(xfer_rsp));
	dcs_mover i_mover (.sys_clk(sys_clk), .rst_n(rst_n), .xfer_req(xfer_req), .xfer_rsp(xfer_rsp),
		.delay(delay), .bus_err(bus_err), .pdone(pdone), .t_mem(t_mem), .t_cnt(16'h0002));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and pulse counter
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (!pcl_oe_n) low_cnt++;
		if (cycles == 40000) begin
			miscompares++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus tasks
	task automatic chk(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		avs_write <= 1'b0;
	endtask
	task automatic rd(input string n, input logic [5:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		rdata = avs_readdata;
		avs_read <= 1'b0;
		if (n != "") chk(n, rdata, e);
	endtask
	task automatic cfg(input logic [31:0] o, d, m, c);
		wr(DCS_OCR_OFF, o);
		wr(DCS_DCR_OFF, d);
		wr(DCS_MAR_OFF, m);
		wr(DCS_MTC_OFF, c);
		wr(DCS_CSR_OFF, 32'h1f);
		base = i_mover.moves;
	endtask
	task automatic idle();
		do rd("", DCS_CSR_OFF, 32'h0); while (rdata[DCS_CSR_ACT] !== 1'b0);
	endtask
	task automatic go();
		wr(DCS_CCR_OFF, 32'h1);
		idle();
	endtask
	function automatic logic [31:0] at(input int j);
		return 32'(i_mover.addrs[base + j]);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs();
		rd("status", DCS_CSR_OFF, 32'h20);
		rd("unmapped", 6'h3c, 32'h0);
		wr(DCS_MAR_OFF, 32'h05abcdef);
		rd("pointer", DCS_MAR_OFF, 32'h05abcdef);
	endtask
	task automatic t_blocks();
		logic [31:0] operation_control_reg [2] = '{32'h100, 32'h201};
		logic [31:0] device_control_reg [2] = '{32'h02, 32'h06};
		int st [2] = '{1, -2};
		for (int r = 0; r < 2; r++) begin
			cfg(operation_control_reg[r], device_control_reg[r], 32'h200, 32'h3);
			go();
			chk("moves", 32'(i_mover.moves - base), 32'h3);
			for (int j = 0; j < 3; j++) chk("addr", at(j), 32'(32'sh200 + j * st[r]));
			rd("mar", DCS_MAR_OFF, 32'(32'sh200 + 3 * st[r]));
			rd("count", DCS_MTC_OFF, 32'h0);
			rd("status", DCS_CSR_OFF, 32'h21);
		end
	endtask
	task automatic t_illegal();
		logic [31:0] sz [6] = '{32'h1, 32'h2, 32'h0, 32'h2, 32'h4, 32'h84};
		logic [31:0] dv [6] = '{32'h02, 32'h02, 32'h06, 32'h06, 32'h00, 32'h06};
		for (int k = 0; k < 6; k++) begin
			cfg(sz[k], dv[k], 32'h200, 32'h2);
			go();
			rd("status", DCS_CSR_OFF, 32'h22);
			chk("moves", 32'(i_mover.moves - base), 32'h0);
		end
	endtask
	task automatic t_chain();
		cfg(32'h118, 32'h02, 32'h0, 32'h0);
		wr(DCS_BAR_OFF, 32'h800);
		go();
		chk("fetch", 32'(i_mover.fetch_addr), 32'h800);
		chk("addr", at(1), 32'h501);
		rd("mar", DCS_MAR_OFF, 32'h05000502);
	endtask
	task automatic t_extreq();
		cfg(32'h180, 32'h02, 32'h200, 32'h2);
		wr(DCS_CCR_OFF, 32'h1);
		repeat (10) @(posedge sys_clk);
		chk("moves", 32'(i_mover.moves - base), 32'h0);
		xfer_request <= 1'b1;
		idle();
		xfer_request <= 1'b0;
		chk("moves", 32'(i_mover.moves - base), 32'h2);
	endtask
	task automatic t_cont();
		cfg(32'h120, 32'h02, 32'h300, 32'h1);
		wr(DCS_BAR_OFF, 32'h400);
		wr(DCS_BTC_OFF, 32'h2);
		delay <= 4'h2;
		wr(DCS_CCR_OFF, 32'h1);
		while (i_mover.moves < base + 3) @(posedge sys_clk);
		ext_abort <= 1'b1;
		idle();
		ext_abort <= 1'b0;
		chk("addr", at(1), 32'h400);
		chk("addr", at(2), 32'h401);
	endtask
	task automatic t_term();
		logic [31:0] ex [5] = '{32'h22, 32'h21, 32'h24, 32'h24, 32'h34};
		for (int k = 0; k < 5; k++) begin
			cfg(32'h100, (k == 4) ? 32'h12 : 32'h02, 32'h600, 32'h4);
			delay <= 4'h8;
			bus_err <= (k == 0);
			pdone <= (k == 1);
			wr(DCS_CCR_OFF, 32'h1);
			if (k == 3) wr(DCS_CCR_OFF, 32'h2);
			ext_abort <= (k == 2);
			pcl_drv <= (k != 4);
			idle();
			ext_abort <= 1'b0;
			pcl_drv <= 1'b1;
			rd("status", DCS_CSR_OFF, ex[k]);
		end
		bus_err <= 1'b0;
		pdone <= 1'b0;
	endtask
	task automatic t_line();
		cfg(32'h100, 32'h0a, 32'h0, 32'h1);
		wr(DCS_INT_OFF, 32'h1);
		pcl_drv <= 1'b0;
		rd("status", DCS_CSR_OFF, 32'h10);
		chk("irq", 32'(line_irq), 32'h1);
		wr(DCS_INT_OFF, 32'h0);
		@(negedge sys_clk);
		chk("irq", 32'(line_irq), 32'h0);
		wr(DCS_DCR_OFF, 32'h03);
		@(negedge sys_clk);
		chk("ready", 32'(device_ready), 32'h1);
		pcl_drv <= 1'b1;
		wr(DCS_DCR_OFF, 32'h01);
		@(negedge sys_clk);
		chk("sync", 32'(sync_enable_clk), 32'h1);
	endtask
	task automatic t_pulse();
		cfg(32'h100, 32'h1a, 32'h100, 32'h1);
		delay <= 4'hf;
		low_cnt = 0;
		go();
		chk("pulse", 32'(low_cnt), 32'h8);
		chk("drive", 32'(pcl_out), 32'h0);
		delay <= 4'h0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Closing report
	task automatic results();
		if (miscompares == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_blocks();
		t_illegal();
		t_chain();
		t_extreq();
		t_cont();
		t_term();
		t_line();
		t_pulse();
		results();
	end
endmodule
